// ---- logic/wsr_status_regs.v ----
`timescale 1ns/1ps
`include "wsr_defines.vh"
module wsr_status_regs #(
  parameter NUM_WK = 3,
  parameter NUM_GP = 2,
  parameter NUM_HS = 4
) (
  input wire clk,
  input wire rst,
  input wire soft_rst,
  input wire [1:0] sbc_mode,
  input wire bus_wake_evt,
  input wire timer_wake_evt,
  input wire [NUM_WK-1:0] wake_pin_evt,
  input wire [NUM_GP-1:0] gp_wake_evt,
  input wire [NUM_HS-1:0] hs_overload_evt,
  input wire [NUM_HS-1:0] hs_openload_evt,
  input wire [NUM_WK-1:0] wake_pin_level,
  input wire [NUM_WK-1:0] wake_pin_cyclic,
  input wire [NUM_WK-1:0] wake_sample_strobe,
  input wire [NUM_GP-1:0] gp_pin_level,
  input wire [2*NUM_GP-1:0] gp_cfg,
  input wire fail_output_test_pin,
  input wire int_pullup_detect,
  input wire [`WSR_ADDR_W-1:0] reg_addr,
  input wire reg_rd,
  input wire reg_clr,
  output reg [7:0] reg_rdata,
  output wire fail_safe_wake
);
  wire [5:0] wake_a_set;
  wire [5:0] wake_a_q;
  wire [NUM_GP-1:0] wake_b_q;
  wire [NUM_HS-1:0] hs_ovl_q;
  wire [NUM_HS-1:0] hs_ol_q;
  wire [NUM_WK-1:0] wk_lvl_q;
  wire [NUM_GP-1:0] gp_lvl_q;
  wire [NUM_WK-1:0] wk_upd;
  wire [NUM_GP-1:0] gp_upd;
  wire any_wake;
  wire run_mode;
  reg dev_mode_r;
  reg pullup_r;
  reg strap_pending_r;
  reg [7:0] rdata_nxt;

  // any wake source, also while in fail-safe
  assign any_wake = bus_wake_evt | timer_wake_evt | (|wake_pin_evt) | (|gp_wake_evt);
  assign fail_safe_wake = (sbc_mode == `WSR_MODE_FAILSAFE) && any_wake;

  // flags latch in every mode, fail-safe included
  assign wake_a_set = {bus_wake_evt, timer_wake_evt, 1'b0, wake_pin_evt};

  wsr_sticky_flags #(.W(6)) u_wake_a (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .set(wake_a_set),
    .clr(reg_clr && (reg_addr == `WSR_ADDR_WAKE_A)),
    .q(wake_a_q)
  );

  wsr_sticky_flags #(.W(NUM_GP)) u_wake_b (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .set(gp_wake_evt),
    .clr(reg_clr && (reg_addr == `WSR_ADDR_WAKE_B)),
    .q(wake_b_q)
  );

  wsr_sticky_flags #(.W(NUM_HS)) u_hs_ovl (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .set(hs_overload_evt),
    .clr(reg_clr && (reg_addr == `WSR_ADDR_HS_OVL)),
    .q(hs_ovl_q)
  );

  wsr_sticky_flags #(.W(NUM_HS)) u_hs_ol (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .set(hs_openload_evt),
    .clr(reg_clr && (reg_addr == `WSR_ADDR_HS_OL)),
    .q(hs_ol_q)
  );

  // live level, or last sample when cyclic sensing owns the pin
  assign wk_upd = ~wake_pin_cyclic | wake_sample_strobe;

  wsr_level_capture #(.W(NUM_WK)) u_wk_lvl (
    .clk(clk),
    .rst(rst),
    .soft_rst(1'b0),
    .level_in(wake_pin_level),
    .update(wk_upd),
    .q(wk_lvl_q)
  );

  assign run_mode = (sbc_mode == `WSR_MODE_NORMAL) || (sbc_mode == `WSR_MODE_STOP);

  genvar g;
  generate
    for (g = 0; g < NUM_GP; g = g + 1) begin : g_gp_upd
      // no sample strobe here: gp pins have no cyclic sense
      assign gp_upd[g] = run_mode && (gp_cfg[2*g+1:2*g] != `WSR_GP_OFF);
    end
  endgenerate

  wsr_level_capture #(.W(NUM_GP)) u_gp_lvl (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .level_in(gp_pin_level),
    .update(gp_upd),
    .q(gp_lvl_q)
  );

  // straps caught on the first edge after reset release, not under reset
  always @(posedge clk) begin
    if (rst) begin
      strap_pending_r <= 1'b1;
      dev_mode_r <= 1'b0;
      pullup_r <= 1'b0;
    end else if (strap_pending_r) begin
      strap_pending_r <= 1'b0;
      dev_mode_r <= fail_output_test_pin;
      pullup_r <= int_pullup_detect;
    end
  end

  // reserved positions are constant zero in every word
  always @* begin
    rdata_nxt = `WSR_RDATA_NONE;
    case (reg_addr)
      `WSR_ADDR_WAKE_A: begin
        rdata_nxt = {2'b00, wake_a_q};
      end
      `WSR_ADDR_WAKE_B: begin
        rdata_nxt = {2'b00, wake_b_q, 4'h0};
      end
      `WSR_ADDR_LEVEL: begin
        rdata_nxt = {dev_mode_r, pullup_r, gp_lvl_q, 1'b0, wk_lvl_q};
      end
      `WSR_ADDR_HS_OVL: begin
        rdata_nxt = {4'h0, hs_ovl_q};
      end
      `WSR_ADDR_HS_OL: begin
        rdata_nxt = {4'h0, hs_ol_q};
      end
      default: begin
        rdata_nxt = `WSR_RDATA_NONE;
      end
    endcase
  end

  // read captures the pre-clear value, so a read-clear frame loses nothing
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `WSR_RDATA_NONE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule

// ---- logic/wsr_defines.vh ----
// Operation
// - sticky wake flags: bus bit5, cyclic timer bit4, wake pins three..one bits2..0
// - sticky wake flags for gp pin two bit5, gp pin one bit4
// - a wake out of fail-safe also sets that source's wake flag
// - reserved bits of every status register always read zero
// - level register: wake pins bits0..2, gp pins bits4..5, 1 means high
// - gp level refreshed in normal and stop when wake, low-side or high-side
// - cyclic-sensed wake pin level holds last sample, rewritten per sampling
// - gp pins never sampled cyclically, only wake pins are
// - gp level still shown when configured as low-side or high-side switch
// - level bit7 shows test pin strap: 0 user, 1 development mode
// - level bit6 is 1 with interrupt pin pull-up, else 0
// - one sticky overload flag per high-side switch, bits3..0
// - one sticky open-load flag per high-side switch, bits3..0
// - power-on or soft reset clears all flags; restart keeps them
`ifndef WSR_DEFINES_VH
`define WSR_DEFINES_VH

`define WSR_ADDR_W 7
`define WSR_ADDR_WAKE_A 7'h46
`define WSR_ADDR_WAKE_B 7'h47
`define WSR_ADDR_LEVEL 7'h48
`define WSR_ADDR_HS_OVL 7'h54
`define WSR_ADDR_HS_OL 7'h55

`define WSR_BIT_BUS_WAKE 5
`define WSR_BIT_TIMER_WAKE 4
`define WSR_BIT_WK_LSB 0
`define WSR_BIT_GP_WAKE_LSB 4
`define WSR_BIT_WK_LVL_LSB 0
`define WSR_BIT_GP_LVL_LSB 4
`define WSR_BIT_PULLUP 6
`define WSR_BIT_DEVMODE 7

`define WSR_RST_FLAGS 8'h00
`define WSR_RDATA_NONE 8'h00

`define WSR_MODE_NORMAL 2'h0
`define WSR_MODE_STOP 2'h1
`define WSR_MODE_SLEEP 2'h2
`define WSR_MODE_FAILSAFE 2'h3

`define WSR_GP_OFF 2'h0
`define WSR_GP_WAKE 2'h1
`define WSR_GP_LOWSIDE 2'h2
`define WSR_GP_HIGHSIDE 2'h3

`endif

// ---- logic/wsr_sticky_flags.v ----
`timescale 1ns/1ps
module wsr_sticky_flags #(
  parameter W = 4
) (
  input wire clk,
  input wire rst,
  input wire soft_rst,
  input wire [W-1:0] set,
  input wire clr,
  output wire [W-1:0] q
);
  reg [W-1:0] flag_r;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_flag
      always @(posedge clk) begin
        if (rst || soft_rst) begin
          flag_r[i] <= 1'b0;
        end else if (set[i]) begin
          flag_r[i] <= 1'b1; // set beats a same-cycle clear
        end else if (clr) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate
  assign q = flag_r;
endmodule

// ---- logic/wsr_level_capture.v ----
`timescale 1ns/1ps
module wsr_level_capture #(
  parameter W = 3
) (
  input wire clk,
  input wire rst,
  input wire soft_rst,
  input wire [W-1:0] level_in,
  input wire [W-1:0] update,
  output wire [W-1:0] q
);
  reg [W-1:0] lvl_r;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lvl
      always @(posedge clk) begin
        if (rst || soft_rst) begin
          lvl_r[i] <= 1'b0;
        end else if (update[i]) begin
          lvl_r[i] <= level_in[i];
        end
      end
    end
  endgenerate
  assign q = lvl_r;
endmodule

// ---- tb/wsr_chk_chk.sv ----
`timescale 1ns/1ps
module wsr_chk (
  input clk,
  input rst,
  input soft_rst,
  input bus_wake_evt,
  input [1:0] gp_wake_evt,
  input [3:0] hs_overload_evt,
  input [3:0] hs_openload_evt,
  input [6:0] reg_addr,
  input reg_rd,
  input [7:0] reg_rdata
);
  wire [7:0] rda = {reg_rd, reg_addr};
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  property p_rsv_a; rda == 8'hc6 |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[3]; endproperty
  a_rsv_a: assert property (p_rsv_a) else $error("wake a reserved");
  property p_rsv_b; rda == 8'hc7 |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[3:0]; endproperty
  a_rsv_b: assert property (p_rsv_b) else $error("wake b reserved");
  property p_rsv_hs; rda[7:1] == 7'h6a |=> reg_rdata[7:4] == 4'h0; endproperty
  a_rsv_hs: assert property (p_rsv_hs) else $error("switch reserved");
  property p_bus; bus_wake_evt ##1 rda == 8'hc6 |=> reg_rdata[5]; endproperty
  a_bus: assert property (p_bus) else $error("bus wake flag");
  property p_gp; gp_wake_evt[1] ##1 rda == 8'hc7 |=> reg_rdata[5]; endproperty
  a_gp: assert property (p_gp) else $error("gp wake flag");
  property p_ovl; hs_overload_evt[3] ##1 rda == 8'hd4 |=> reg_rdata[3]; endproperty
  a_ovl: assert property (p_ovl) else $error("overload flag");
  property p_ol; hs_openload_evt[0] ##1 rda == 8'hd5 |=> reg_rdata[0]; endproperty
  a_ol: assert property (p_ol) else $error("open-load flag");
  property p_srst; soft_rst && !hs_overload_evt ##1 rda == 8'hd4 |=> !reg_rdata; endproperty
  a_srst: assert property (p_srst) else $error("soft reset kept");
endmodule
bind wsr_status_regs wsr_chk u_wsr_chk (.*);

// ---- tb/wsr_host.sv ----
`timescale 1ns/1ps
module wsr_host (
  input clk,
  output reg [6:0] reg_addr = 7'h00,
  output reg reg_rd = 1'h0,
  output reg reg_clr = 1'h0
);
  // read and clear go out together: data is the pre-clear copy
  task cmd(input [6:0] a);
    begin
      @(posedge clk);
      #2 {reg_addr, reg_rd, reg_clr} = {a, 2'h3};
      @(posedge clk);
      #2 {reg_rd, reg_clr} = 2'h0;
    end
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  reg clk = 1'h0;
  reg rst, soft_rst, fail_output_test_pin, int_pullup_detect;
  reg [1:0] sbc_mode, gp_pin_level;
  reg [2:0] wake_pin_level, wake_pin_cyclic, wake_sample_strobe;
  reg [3:0] gp_cfg;
  reg [14:0] ev;
  reg [31:0] x = 32'h0;
  wire [6:0] reg_addr;
  wire reg_rd, reg_clr, fail_safe_wake;
  wire [7:0] reg_rdata;
  integer errors = 0, n_checks = 0, seed = 46872, i, k;
  wsr_status_regs u_wsr_status_regs (.*, .bus_wake_evt(ev[14]), .timer_wake_evt(ev[13]),
    .wake_pin_evt(ev[12:10]), .gp_wake_evt(ev[9:8]), .hs_overload_evt(ev[7:4]),
    .hs_openload_evt(ev[3:0]));
  wsr_host u_wsr_host (.*);
  function [7:0] lvl(input [1:0] g, input [2:0] w);
    lvl = {fail_output_test_pin, int_pullup_detect, g, 1'h0, w};
  endfunction
  // events drop as the read goes out, so a clear never meets a live event
  task chk(input [6:0] a, input [7:0] e);
    begin
      fork
        u_wsr_host.cmd(a);
        @(posedge clk) #2 {ev, soft_rst} = 16'h0;
      join
      n_checks = n_checks + 1;
      if (reg_rdata !== e) begin
        errors = errors + 1;
        $display("[ERR] reg %h exp %h got %h", a, e, reg_rdata);
      end
    end
  endtask
  task end_of_test;
    begin
      if (errors == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial forever #25 clk = ~clk;
  initial begin
    #100000;
    errors = errors + 1;
    end_of_test;
  end
  initial begin
    {rst, soft_rst, ev, wake_pin_cyclic, wake_sample_strobe} = 23'h400000;
    {sbc_mode, gp_cfg, fail_output_test_pin, int_pullup_detect, wake_pin_level,
      gp_pin_level} = 13'h07d6;
    repeat (10) @(posedge clk);
    #2 rst = 1'h0;
    chk(7'h49, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      ev = $random(seed);
      sbc_mode = $random(seed);
      x = x | {4'h0, ev[3:0], 4'h0, ev[7:4], 2'h0, ev[9:8], 6'h0, ev[14:13], 1'h0, ev[12:10]};
      k = i % 4 * 8;
      chk({i[1] ? 6'h2a : 6'h23, i[0]}, x[k+:8]);
      x[k+:8] = 8'h00;
    end
    soft_rst = 1'h1;
    chk(7'h54, 8'h00);
    for (k = 0; k < 4; k = k + 1)
      chk({k[1] ? 6'h2a : 6'h23, k[0]}, 8'h00);
    {sbc_mode, wake_pin_level, gp_pin_level} = 7'h09;
    chk(7'h48, lvl(2'h1, 3'h2));
    {gp_cfg, wake_pin_cyclic, wake_pin_level, gp_pin_level} = 12'h0f6;
    chk(7'h48, lvl(2'h1, 3'h2));
    wake_sample_strobe = 3'h7;
    @(posedge clk);
    #2 wake_sample_strobe = 3'h0;
    chk(7'h48, lvl(2'h1, 3'h5));
    sbc_mode = 2'h3;
    ev = 15'h4000;
    #1 n_checks = n_checks + 1;
    if (fail_safe_wake !== 1'h1) begin
      errors = errors + 1;
      $display("[ERR] fail_safe_wake exp 1 got %b", fail_safe_wake);
    end
    // sleep mode: gp level must hold even with a live cfg
    {sbc_mode, gp_cfg, gp_pin_level} = 8'h96;
    chk(7'h48, lvl(2'h1, 3'h5));
    chk(7'h46, 8'h20);
    // second power-on reset mid-run with the other strap levels
    rst = 1'h1;
    {fail_output_test_pin, int_pullup_detect} = 2'h1;
    ev = 15'h7fff;
    repeat (2) @(posedge clk);
    #2 rst = 1'h0;
    ev = 15'h0;
    chk(7'h48, lvl(2'h0, 3'h0));
    chk(7'h46, 8'h00);
    chk(7'h55, 8'h00);
    end_of_test;
  end
endmodule
